// file: design/rcc_pkg.sv
/*
  Package for the reset cause classifier: register map, field layout,
  reset types, sequencer states and timing constants.
  Assumes a single 50 MHz suspend-well clock.
*/
package rcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] RCC_OFS_RESET_CONTROL = 12'hcf9;
  localparam logic [11:0] RCC_OFS_STATUS        = 12'hd00;
  localparam logic [11:0] RCC_OFS_CONFIG        = 12'hd04;

  // reset_control fields
  // bit 0: the 06h and 0Eh commands never set it themselves
  localparam int RCC_BIT_GLOBAL    = 0;
  localparam int RCC_BIT_RESET_CPU = 2;
  localparam int RCC_BIT_FULL      = 3;
  localparam logic [7:0] RCC_CMD_HOST_PLAIN = 8'h06;
  localparam logic [7:0] RCC_CMD_HOST_CYCLE = 8'h0e;
  localparam logic [7:0] RCC_RESET_CONTROL_INIT = 8'h00;

  // config fields
  localparam int RCC_CFG_DEEP_EN = 0;
  localparam logic [1:0] RCC_CONFIG_INIT = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint RCC_CLK_HZ       = 50000000;
  localparam longint RCC_TIMEOUT_MS   = 4000;
  localparam longint RCC_TIMEOUT_CYC  = RCC_CLK_HZ / 1000 * RCC_TIMEOUT_MS;
  localparam longint RCC_OVERRIDE_MS  = 4000;
  localparam longint RCC_OVERRIDE_CYC = RCC_CLK_HZ / 1000 * RCC_OVERRIDE_MS;
  localparam int     RCC_ASSERT_CYC   = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCC_RT_NONE  = 3'h0,
    RCC_RT_HOST  = 3'h1,
    RCC_RT_CYCLE = 3'h2,
    RCC_RT_SOFT  = 3'h3,
    RCC_RT_GLOB  = 3'h4
  } rcc_type_e;

  typedef enum logic [5:0] {
    RCC_ST_IDLE  = 6'h01,
    RCC_ST_WARN  = 6'h02,
    RCC_ST_RESET = 6'h04,
    RCC_ST_OFF   = 6'h08,
    RCC_ST_DEEP  = 6'h10,
    RCC_ST_WAKE  = 6'h20
  } rcc_state_e;

  // grouped trigger inputs
  typedef struct packed {
    logic smbCycle;
    logic smbPlain;
    logic smbPowerDown;
    logic watchdogSecond;
    logic thermalSensor;
    logic mgmtHostPlain;
    logic mgmtHostCycle;
    logic mgmtGlobal;
    logic mgmtOverride;
    logic mgmtWatchdog;
    logic mgmtHwError;
    logic mgmtHostPowerDown;
    logic pmWatchdog;
    logic cpuShutdown;
  } rcc_trig_s;

  // sleep-state context
  typedef struct packed {
    logic working;
    logic sleeping;
    logic softwareSleep;
    logic deepAllowed;
    logic wakeEvent;
  } rcc_ctx_s;

endpackage : rcc_pkg

// file: design/rcc_reset_cause_classifier.sv
/*
  Reset cause classifier: ranks triggers, runs warning and reset sequence.
  Assumes async pins, one-cycle clk triggers, AXI4-Lite registers.
*/
// The AXI4-Lite register port is this design's own decision.
//
// Overview of operation
// - 0Eh write, global clear: cycled host reset
// - 06h write, global clear: plain host reset
// - 06h/0Eh with global set: global reset
// - reset button: bit 3 picks cycle
// - second watchdog expiry: plain host reset
// - power-good failures give global reset; system power good only while working
// - cpu thermal trip: soft-off, platform reset
// - catastrophic internal temperature: soft-off
// - power button override hold: soft-off
// - cpu shutdown cycle follows control bits
// - management requests map directly
// - watchdog or hardware error: soft-off
// - host power down waits for wake
// - sequence timeout or cpu power stuck: global
// - plain host reset dropped while asleep
// - cycled reset in software sleep skips warning
// - global reset: no warning, no delay
// - missing acknowledge escalates to global
// - soft-off enters deep sleep when allowed
// - warn cpu, assert reset after acknowledge
// - acknowledge timeout after four seconds
// - soft-off holds host until wake
`timescale 1ns/1ps
`default_nettype none

module rcc_reset_cause_classifier
  import rcc_pkg::*;
#(
  parameter longint TIMEOUT_CYC  = RCC_TIMEOUT_CYC,
  parameter longint OVERRIDE_CYC = RCC_OVERRIDE_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        system_reset_button_n,
  input  wire logic        main_power_good,
  input  wire logic        deep_well_power_good,
  input  wire logic        system_power_good,
  input  wire logic        cpu_thermal_trip_n,
  input  wire logic        cpu_power_good,
  input  wire logic        power_button_n,
  // same-clock triggers and context
  input  wire rcc_trig_s   trig,
  input  wire rcc_ctx_s    ctx,
  // processor handshake
  output var  logic        resetWarn,
  input  wire logic        resetAck,
  // results
  output var  logic        platform_reset_n,
  output var  logic        powerCycle,
  output var  logic        hostOff,
  output var  logic        deep_sleep_state,
  output var  logic [2:0]  lastType
);

  // --------------------
  // pin synchronisers: three flops, change counted when 2 and 3 agree
  // --------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pinState;
  assign pinRaw = {power_button_n, cpu_power_good, cpu_thermal_trip_n, system_power_good,
                   deep_well_power_good, main_power_good, system_reset_button_n};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync1[gi]    <= 1'b1;
          sync2[gi]    <= 1'b1;
          sync3[gi]    <= 1'b1;
          pinState[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pinRaw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pinState[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] pinPrev;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinPrev <= '1;
    end else begin
      pinPrev <= pinState;
    end
  end

  wire [NPIN-1:0] pinFall = pinPrev & ~pinState;
  wire buttonFall  = pinFall[0];
  wire mainFail    = pinFall[1];
  wire deepFail    = pinFall[2];
  wire sysFail     = pinFall[3];
  wire thermFall   = pinFall[4];
  wire cpuPgLow    = ~pinState[5];
  wire pwrBtnLow   = ~pinState[6];

  // --------------------
  // axi4-lite slave
  // --------------------
  logic [7:0]  resetControl;
  logic [1:0]  config_q;
  logic        haveAw;
  logic        haveW;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  wire wrFire  = haveAw && haveW && !s_axi_bvalid;
  wire wrCtl   = wrFire && (awAddr == RCC_OFS_RESET_CONTROL);
  wire wrCfg   = wrFire && (awAddr == RCC_OFS_CONFIG);
  wire wrKnown = wrCtl || wrCfg;
  // byte address cf9 sits in lane 1 of its word; accept lane 0 too
  wire [7:0] ctlByte = wStrb[1] ? wData[15:8] : wData[7:0];
  wire ctlLane = wStrb[1] || wStrb[0];
  wire ctlWr   = wrCtl && ctlLane;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrKnown ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // reset_control keeps its value; bit 2 is always written as 0 and never reads back set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resetControl <= RCC_RESET_CONTROL_INIT;
      config_q     <= RCC_CONFIG_INIT;
    end else begin
      if (ctlWr) begin
        resetControl <= ctlByte & ~(8'h1 << RCC_BIT_RESET_CPU);
      end
      if (wrCfg && wStrb[0]) begin
        config_q <= wData[1:0];
      end
    end
  end

  // read side
  rcc_state_e  state;
  wire rdCtl = s_axi_araddr == RCC_OFS_RESET_CONTROL;
  wire rdSt  = s_axi_araddr == RCC_OFS_STATUS;
  wire rdCfg = s_axi_araddr == RCC_OFS_CONFIG;
  wire [31:0] rdMux = rdCtl ? {16'h0, resetControl, resetControl} :
                      rdSt  ? {16'h0, 2'h0, state, 5'h0, lastType} :
                      rdCfg ? {30'h0, config_q} : 32'h0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= (rdCtl || rdSt || rdCfg) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------
  // trigger classification
  // --------------------
  wire globalBit = resetControl[RCC_BIT_GLOBAL];
  wire fullBit   = resetControl[RCC_BIT_FULL];
  wire cfCycle = ctlWr && ctlByte == RCC_CMD_HOST_CYCLE;
  wire cfPlain = ctlWr && ctlByte == RCC_CMD_HOST_PLAIN;
  wire cfGlob  = (cfCycle || cfPlain) && globalBit;

  logic [$clog2(OVERRIDE_CYC+1)-1:0] btnCnt;
  wire btnHit = pwrBtnLow && btnCnt == ($bits(btnCnt))'(OVERRIDE_CYC - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      btnCnt <= '0;
    end else if (!pwrBtnLow) begin
      btnCnt <= '0;
    end else if (btnCnt != ($bits(btnCnt))'(OVERRIDE_CYC)) begin
      btnCnt <= btnCnt + 1'b1;
    end
  end

  // sequence timer shared by warning wait and reset entry
  logic [$clog2(TIMEOUT_CYC+1)-1:0] seqCnt;
  wire seqTimeout = seqCnt == ($bits(seqCnt))'(TIMEOUT_CYC - 1);

  // button and shutdown cycle follow control bits
  wire shutGlob = trig.cpuShutdown && globalBit;
  wire shutHost = trig.cpuShutdown && !globalBit;

  wire reqGlob = cfGlob || mainFail || deepFail || (sysFail && ctx.working)
               || shutGlob || trig.mgmtGlobal || (seqTimeout && state == RCC_ST_RESET)
               || (cpuPgLow && ctx.working);
  wire reqSoft = trig.smbPowerDown || thermFall || trig.thermalSensor || btnHit
               || trig.mgmtOverride || trig.mgmtWatchdog || trig.mgmtHwError
               || trig.pmWatchdog;
  // host power down is a cycled reset that waits for wake
  wire reqCycle = (cfCycle && !globalBit) || (buttonFall && fullBit) || trig.smbCycle
               || (shutHost && fullBit) || trig.mgmtHostCycle || trig.mgmtHostPowerDown;
  // plain host reset dropped while asleep
  wire reqPlain = ((cfPlain && !globalBit) || (buttonFall && !fullBit) || trig.smbPlain
               || trig.watchdogSecond || (shutHost && !fullBit) || trig.mgmtHostPlain)
               && !ctx.sleeping;

  wire rcc_type_e reqType = reqGlob  ? RCC_RT_GLOB  :
                            reqSoft  ? RCC_RT_SOFT  :
                            reqCycle ? RCC_RT_CYCLE :
                            reqPlain ? RCC_RT_HOST  : RCC_RT_NONE;

  // --------------------
  // sequencer
  // --------------------
  rcc_state_e next_state;
  logic [4:0] holdCnt;
  logic       waitWake;
  wire holdDone = holdCnt == 5'(RCC_ASSERT_CYC - 1);
  wire busy     = state == RCC_ST_WARN || state == RCC_ST_RESET;
  // global and soft-off pre-empt any sequence under way
  wire preempt  = reqType == RCC_RT_GLOB || reqType == RCC_RT_SOFT;
  wire skipWarn = ctx.softwareSleep;

  always_comb begin
    next_state = state;
    unique case (state)
      RCC_ST_IDLE, RCC_ST_WAKE: begin
        if (reqType == RCC_RT_GLOB || reqType == RCC_RT_SOFT) begin
          next_state = RCC_ST_RESET;
        end else if (reqType != RCC_RT_NONE) begin
          next_state = skipWarn ? RCC_ST_RESET : RCC_ST_WARN;
        end
      end
      RCC_ST_WARN: begin
        if (preempt || resetAck || seqTimeout) begin
          next_state = RCC_ST_RESET;
        end
      end
      RCC_ST_RESET: begin
        if (preempt) begin
          next_state = RCC_ST_RESET;
        end else if (holdDone) begin
          next_state = (lastType == RCC_RT_SOFT || waitWake) ? RCC_ST_OFF : RCC_ST_IDLE;
        end
      end
      RCC_ST_OFF: begin
        // deep sleep when enabled and allowed
        if (ctx.wakeEvent) begin
          next_state = RCC_ST_IDLE;
        end else if (config_q[RCC_CFG_DEEP_EN] && ctx.deepAllowed && lastType == RCC_RT_SOFT) begin
          next_state = RCC_ST_DEEP;
        end
      end
      RCC_ST_DEEP: begin
        if (ctx.wakeEvent) begin
          next_state = RCC_ST_IDLE;
        end
      end
    endcase
  end

  wire enterReset = next_state == RCC_ST_RESET && (state != RCC_ST_RESET || preempt);
  wire startSeq   = (state == RCC_ST_IDLE || state == RCC_ST_WAKE) && next_state != state;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state    <= RCC_ST_IDLE;
      lastType <= RCC_RT_NONE;
      waitWake <= 1'b0;
      seqCnt   <= '0;
      holdCnt  <= '0;
    end else begin
      state <= next_state;
      if (startSeq) begin
        lastType <= reqType;
        waitWake <= trig.mgmtHostPowerDown && reqType == RCC_RT_CYCLE;
      end else if (state == RCC_ST_WARN && !resetAck && seqTimeout && !preempt) begin
        lastType <= RCC_RT_GLOB;
      end else if (busy && preempt) begin
        lastType <= reqType;
      end
      seqCnt  <= (startSeq || next_state != state || next_state == RCC_ST_IDLE) ? '0
                 : seqCnt + 1'b1;
      holdCnt <= enterReset ? '0 : (state == RCC_ST_RESET ? holdCnt + 1'b1 : '0);
    end
  end

  // --------------------
  // registered outputs
  // --------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resetWarn        <= 1'b0;
      platform_reset_n <= 1'b0;
      powerCycle       <= 1'b0;
      hostOff          <= 1'b0;
      deep_sleep_state <= 1'b0;
    end else begin
      resetWarn        <= next_state == RCC_ST_WARN;
      platform_reset_n <= !(next_state == RCC_ST_RESET || next_state == RCC_ST_OFF
                            || next_state == RCC_ST_DEEP);
      powerCycle       <= next_state == RCC_ST_RESET && lastType != RCC_RT_HOST && !startSeq
                          || (startSeq && reqType != RCC_RT_HOST && next_state == RCC_ST_RESET);
      hostOff          <= next_state == RCC_ST_OFF || next_state == RCC_ST_DEEP;
      deep_sleep_state <= next_state == RCC_ST_DEEP;
    end
  end

endmodule : rcc_reset_cause_classifier

`default_nettype wire

// file: dv/rcc_reset_cause_classifier_chk.sv
/*
  Assertions on the classifier's ports.
  Assumes one clk domain, async active-low resetn.
*/
`timescale 1ns/1ps
`default_nettype none

module rcc_reset_cause_classifier_chk
  import rcc_pkg::*;
#(
  parameter longint TIMEOUT_CYC = 100
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       main_power_good,
  input wire rcc_trig_s  trig,
  input wire rcc_ctx_s   ctx,
  input wire logic       resetWarn,
  input wire logic       resetAck,
  input wire logic       platform_reset_n,
  input wire logic       powerCycle,
  input wire logic       hostOff,
  input wire logic [2:0] lastType
);
  // --------------------
  // helpers
  // --------------------
  logic [15:0] lowCnt;
  logic [15:0] warnCnt;
  wire         idle = platform_reset_n && !resetWarn && !hostOff;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt  <= 16'h0;
      warnCnt <= 16'h0;
    end else begin
      lowCnt  <= platform_reset_n ? 16'h0 : lowCnt + 16'h1;
      warnCnt <= resetWarn ? warnCnt + 16'h1 : 16'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence globalOn;
    !platform_reset_n && powerCycle && lastType == 3'h4;
  endsequence

  // --------------------
  // properties
  // --------------------
  a_global_direct:
    assert property (trig.mgmtGlobal |=> !resetWarn ##0 globalOn)
    else $error("global not direct");
  a_rank_severe:
    assert property (trig.mgmtOverride && trig.mgmtHostCycle && !trig.mgmtGlobal
                     |=> lastType == 3'h3 && !resetWarn)
    else $error("soft-off rank lost");
  a_soft_off:
    assert property ((trig.pmWatchdog || trig.mgmtWatchdog || trig.mgmtHwError)
                     && !trig.mgmtGlobal |=> !platform_reset_n && lastType == 3'h3)
    else $error("no soft-off");
  a_ack_reset:
    assert property (resetWarn && resetAck |=> !resetWarn && !platform_reset_n)
    else $error("ack gave no reset");
  a_ack_timeout:
    assert property (warnCnt <= TIMEOUT_CYC + 2)
    else $error("warning too long");
  a_escalate_global:
    assert property ($fell(resetWarn) && !$past(resetAck) |-> ##[0:2] globalOn)
    else $error("no escalation");
  a_hold_count:
    assert property ($rose(platform_reset_n) && !$past(hostOff)
                     && lastType inside {3'h1, 3'h2} |-> lowCnt == 16'd16)
    else $error("hold length wrong");
  a_sleep_drop:
    assert property ($onehot(trig) && trig.mgmtHostPlain && ctx.sleeping && idle
                     |=> idle[*3])
    else $error("plain reset taken asleep");
  a_sw_sleep:
    assert property ($onehot(trig) && trig.mgmtHostCycle && ctx.sleeping
                     && ctx.softwareSleep && idle
                     |=> !resetWarn && !platform_reset_n && powerCycle)
    else $error("sleep reset not direct");
  a_cycle_warn:
    assert property ($onehot(trig) && trig.mgmtHostCycle && !ctx.sleeping && idle
                     |=> resetWarn && platform_reset_n)
    else $error("no warning first");
  a_power_fail:
    assert property ($fell(main_power_good) |-> ##[1:8] globalOn)
    else $error("no global on power loss");
  a_wake_hold:
    assert property (hostOff && !ctx.wakeEvent && trig == '0 |=> !platform_reset_n)
    else $error("left soft-off early");
endmodule : rcc_reset_cause_classifier_chk

bind rcc_reset_cause_classifier rcc_reset_cause_classifier_chk
  #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk, .resetn, .main_power_good, .trig, .ctx, .resetWarn, .resetAck,
  .platform_reset_n, .powerCycle, .hostOff, .lastType);

`default_nettype wire

// file: dv/rcc_cpu_model.sv
/*
  Processor side of the warning handshake.
  Assumes ackEnable, ackDelay change between warnings.
*/
`timescale 1ns/1ps
`default_nettype none

module rcc_cpu_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       resetWarn,
  input  wire logic       ackEnable,
  input  wire logic [7:0] ackDelay,
  output var  logic       resetAck
);
  logic [7:0] waitCnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitCnt  <= 8'h0;
      resetAck <= 1'b0;
    end else begin
      resetAck <= resetWarn && ackEnable && waitCnt == ackDelay;
      waitCnt  <= resetWarn ? waitCnt + 8'h1 : 8'h0;
    end
  end
endmodule : rcc_cpu_model

`default_nettype wire

// file: dv/rcc_reset_cause_classifier_tb.sv
/*
  Bench: register cases, then trigger table, deep sleep, sleep, timeout, abort cases.
  Assumes checker bound in, cpu model answers warnings.
*/
`timescale 1ns/1ps
`default_nettype none

module rcc_reset_cause_classifier_tb
  import rcc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  pre;
    logic [7:0]  cmd;
    logic [3:0]  pin;
    logic [15:0] t;
    logic [3:0]  ty;
    logic [3:0]  hold;
  } rcc_row_s;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [6:0]  pinVec = 7'h7f;
  rcc_trig_s   trig = '0;
  rcc_ctx_s    ctx = 5'h10;
  logic        resetWarn, resetAck, platform_reset_n, powerCycle, hostOff, deep_sleep_state;
  logic [2:0]  lastType;
  logic        ackEnable = 1'b1;
  logic [7:0]  ackDelay = 8'h01;
  int          warnSeen = 0;
  int          checks = 0;
  int          mismatches = 0;

  // --------------------
  // rows: preset_command_pin_trigger_type_hostoff
  // --------------------
  rcc_row_s rows [30] = '{
    44'h00_0e_7_0000_2_0, 44'h00_06_7_0000_1_0, 44'h01_06_7_0000_4_0, 44'h01_0e_7_0000_4_0,
    44'h00_00_6_0000_1_0, 44'h08_00_6_0000_2_0, 44'h00_00_0_0000_4_0, 44'h00_00_1_0000_4_0,
    44'h00_00_2_0000_4_0, 44'h00_00_3_0000_3_1, 44'h00_00_4_0000_4_0, 44'h00_00_5_0000_3_1,
    44'h00_00_7_2000_2_0, 44'h00_00_7_1000_1_0, 44'h00_00_7_0800_3_1, 44'h00_00_7_0400_1_0,
    44'h00_00_7_0200_3_1, 44'h00_00_7_0100_1_0, 44'h00_00_7_0080_2_0, 44'h00_00_7_0040_4_0,
    44'h00_00_7_0020_3_1, 44'h00_00_7_0010_3_1, 44'h00_00_7_0008_3_1, 44'h00_00_7_0004_2_1,
    44'h00_00_7_0002_3_1, 44'h01_00_7_0001_4_0, 44'h08_00_7_0001_2_0, 44'h00_00_7_0001_1_0,
    44'h00_00_7_00e0_4_0, 44'h00_00_7_00a0_3_1};

  rcc_reset_cause_classifier #(.TIMEOUT_CYC(100), .OVERRIDE_CYC(100)) dut (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .main_power_good(pinVec[0]), .deep_well_power_good(pinVec[1]),
    .system_power_good(pinVec[2]), .cpu_thermal_trip_n(pinVec[3]),
    .cpu_power_good(pinVec[4]), .power_button_n(pinVec[5]),
    .system_reset_button_n(pinVec[6]), .trig, .ctx, .resetWarn, .resetAck,
    .platform_reset_n, .powerCycle, .hostOff, .deep_sleep_state, .lastType);

  rcc_cpu_model cpu (.clk, .resetn, .resetWarn, .ackEnable, .ackDelay, .resetAck);

  always #10 clk = ~clk;
  always @(posedge clk) if (resetWarn) warnSeen <= warnSeen + 1;

  // --------------------
  // tasks
  // --------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chkVal

  task automatic giveUp(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      report_and_stop();
    end
  endtask : giveUp

  task automatic axiWrite(input logic [11:0] a, input logic [7:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0, v, v};
    s_axi_wstrb   <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    giveUp(n, 50);
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    giveUp(n, 50);
  endtask : axiRead

  task automatic waitRst(input logic lvl, input int lim, output int n);
    n = 0;
    while (platform_reset_n !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    giveUp(n, lim);
  endtask : waitRst

  task automatic pulse(input rcc_trig_s t);
    trig <= t;
    @(posedge clk);
    trig <= '0;
  endtask : pulse

  task automatic runRow(input rcc_row_s w, input int i);
    logic [1:0] r;
    int         n;
    int         w0;
    axiWrite(RCC_OFS_RESET_CONTROL, w.pre, r);
    w0 = warnSeen;
    ackDelay <= i[0] ? 8'h01 : 8'h28;
    if (w.cmd != 8'h00) axiWrite(RCC_OFS_RESET_CONTROL, w.cmd, r);
    else if (w.pin != 4'h7) pinVec[w.pin[2:0]] <= 1'b0;
    else pulse(w.t[13:0]);
    waitRst(1'b0, 400, n);
    pinVec <= 7'h7f;
    chkVal(powerCycle, w.ty != 4'h1, "power cycle");
    chkVal(warnSeen != w0, w.ty < 4'h3, "warning sent");
    repeat (30) @(posedge clk);
    chkVal(lastType, w.ty, "reset type");
    chkVal(hostOff, w.hold, "host held off");
    chkVal(platform_reset_n, w.hold == 4'h0, "platform reset");
    if (w.hold) ctx.wakeEvent <= 1'b1;
    waitRst(1'b1, 100, n);
    if (w.hold) ctx.wakeEvent <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : runRow

  // --------------------
  // sequence
  // --------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    int          w0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    axiRead(RCC_OFS_RESET_CONTROL, d, r);
    chkVal(d, 32'h0, "control at reset");
    axiRead(RCC_OFS_STATUS, d, r);
    chkVal(d, 32'h100, "status at reset");
    axiWrite(RCC_OFS_RESET_CONTROL, 8'h0a, r);
    axiRead(RCC_OFS_RESET_CONTROL, d, r);
    chkVal(d, 32'h0a0a, "control readback");
    axiWrite(12'h010, 8'h5a, r);
    chkVal(r, 2'h2, "unmapped write");
    axiRead(12'h010, d, r);
    chkVal(d, 32'h0, "unmapped read data");
    chkVal(r, 2'h2, "unmapped read resp");
    for (int i = 0; i < 30; i++) runRow(rows[i], i);
    // deep sleep after soft-off
    axiWrite(RCC_OFS_CONFIG, 8'h01, r);
    ctx.deepAllowed <= 1'b1;
    pulse(14'h0002);
    n = 0;
    while (deep_sleep_state !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chkVal(deep_sleep_state, 1'b1, "deep sleep");
    ctx.wakeEvent <= 1'b1;
    waitRst(1'b1, 100, n);
    ctx <= 5'h10;
    axiWrite(RCC_OFS_CONFIG, 8'h00, r);
    // sleeping: plain dropped, cycled done without warning
    ctx <= 5'h1c;
    w0 = warnSeen;
    pulse(14'h0100);
    repeat (10) @(posedge clk);
    chkVal(platform_reset_n, 1'b1, "plain reset in sleep");
    pulse(14'h0080);
    repeat (2) @(posedge clk);
    chkVal(platform_reset_n, 1'b0, "cycled reset in sleep");
    chkVal(warnSeen != w0, 1'b0, "no warning in sleep");
    waitRst(1'b1, 100, n);
    ctx <= 5'h10;
    // withheld acknowledge
    ackEnable <= 1'b0;
    @(posedge clk);
    pulse(14'h0080);
    waitRst(1'b0, 200, n);
    chkVal((n >= 100) && (n <= 110), 1'b1, "ack timeout span");
    repeat (3) @(posedge clk);
    chkVal(lastType, 3'h4, "escalated type");
    waitRst(1'b1, 100, n);
    // reset abort in mid-warning
    pulse(14'h0080);
    repeat (5) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chkVal({resetWarn, platform_reset_n}, 2'h0, "abort by reset");
    resetn <= 1'b1;
    ackEnable <= 1'b1;
    repeat (3) @(posedge clk);
    chkVal(platform_reset_n, 1'b1, "release after abort");
    report_and_stop();
  end
endmodule : rcc_reset_cause_classifier_tb

`default_nettype wire
